// [pic_pkg.sv]
// Purpose: shared constants, types and helpers of the priority interrupt controller
// Assumes: eight request levels, 8-bit host data bus
// Notes: field positions are bit indices inside the written command byte
package pic_pkg;
	// init sequence progress
	typedef enum logic [2:0] {ST_IDLE, ST_W2, ST_W3, ST_W4, ST_READY} pic_init_t;
	// first init word fields
	localparam int F1_HI = 7;
	localparam int F1_SEL = 4;
	localparam int F1_LEVEL_TRIGGER_BIT = 3;
	localparam int F1_ADI = 2;
	localparam int F1_SINGLE_CONTROLLER_BIT = 1;
	localparam int F1_IC4 = 0;
	// mode option word fields
	localparam int F4_SPECIAL_NESTING_BIT = 4;
	localparam int F4_BUF = 3;
	localparam int F4_MS = 2;
	localparam int F4_AUTO_EOI_BIT = 1;
	localparam int F4_UPM = 0;
	// operation word fields
	localparam int FO_R = 7;
	localparam int FO_SL = 6;
	localparam int FO_EOI = 5;
	localparam int FO_ENABLE_SPECIAL_MASK_BIT = 6;
	localparam int FO_SMM = 5;
	localparam int FO_OP_WORD_MASK_MODE_READ = 3;
	// rotate/select/eoi codes
	localparam logic [2:0] OP_NS_EOI = 3'h1;
	localparam logic [2:0] OP_SP_EOI = 3'h3;
	localparam logic [2:0] OP_ROT_EOI = 3'h5;
	localparam logic [2:0] OP_ROT_SET = 3'h4;
	localparam logic [2:0] OP_ROT_CLR = 3'h0;
	// reset values and fixed bytes
	localparam logic [7:0] CALL_CODE = 8'hcd;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] CASMAP_RST = 8'h07;
	localparam logic [2:0] LOW_RST = 3'h7;
	localparam logic [2:0] DEFAULT_LVL = 3'h7;
	localparam logic [1:0] LAST_IDX_CALL = 2'h2;
	localparam logic [1:0] LAST_IDX_VEC = 2'h1;
	// pin synchroniser width: req 8, data 8, cas 3, wr_n, cs_n, a0, ack_n, sp_n
	localparam int SYNC_W = 24;
	// level that holds a given rank when low is the lowest priority level
	function automatic logic [2:0] pic_level_of(input logic [2:0] low, input logic [2:0] rank);
		pic_level_of = low + 3'h1 + rank;
	endfunction : pic_level_of
endpackage : pic_pkg

// [pic_prio.sv]
// Purpose: priority resolver, picks the request to raise and the top in-service level
// Assumes: purely combinational, inputs come from registers of the parent
// Notes: scanning starts just above the lowest level, so rotation is free
`timescale 1ns/1ns
`default_nettype none
module pic_prio
(
	// state to resolve
	input wire logic [7:0] i_req,
	input wire logic [7:0] i_isr,
	input wire logic [7:0] i_mask,
	input wire logic [2:0] i_low,
	input wire logic i_smm,
	input wire logic [7:0] i_same_ok,
	// results
	output logic o_int_valid,
	output logic [2:0] o_int_level,
	output logic o_top_valid,
	output logic [2:0] o_top_level
);
	import pic_pkg::*;
	logic [7:0] act_isr; // in-service bits that still count
	// masked in-service bits neither block nor take a non-specific clear in special mask
	assign act_isr = i_smm ? (i_isr & ~i_mask) : i_isr;
	// scan ranks from highest priority down
	always_comb
	begin
		logic blocked;
		logic [2:0] lvl;
		blocked = 1'b0;
		lvl = 3'h0;
		o_int_valid = 1'b0;
		o_int_level = 3'h0;
		o_top_valid = 1'b0;
		o_top_level = 3'h0;
		for (int k = 0; k < 8; k++)
		begin
			lvl = pic_level_of(i_low, 3'(k));
			// same level passes only where special nesting allows it
			if (!blocked && !o_int_valid && i_req[lvl] && (!act_isr[lvl] || i_same_ok[lvl]))
			begin
				o_int_valid = 1'b1;
				o_int_level = lvl;
			end
			// an in-service level shuts out itself and everything below
			if (act_isr[lvl] && !o_top_valid)
			begin
				o_top_valid = 1'b1;
				o_top_level = lvl;
				blocked = 1'b1;
			end
		end
	end
endmodule : pic_prio
`default_nettype wire

// [pic_ctrl.sv]
// Purpose: programmable eight-level priority interrupt controller core
// Assumes: host strobes and pins are asynchronous and pass two flip-flops
// Notes: two-way pins split into in, out and output enable
// What this block does
// - call mode spaces entries 4 or 8
// - vector mode byte is base[7:3] plus level
// - level trigger bit disables edge detection
// - single controller skips the third word
// - fourth word expected only when requested
// - cascaded third word loads slave register
// - master drives call byte and cascade code
// - slave matches cascade id, drives later bytes
// - buffered mode: enable output, role bit
// - special nesting bit selects special nested mode
// - host mode bit picks acknowledge format
// - operation write with A0 loads mask
// - level bits name level; R,SL,EOI choose operation
// - enable bit lets special-mask bit switch mode
// - default fully nested, level 0 highest
// - acknowledge sets in-service, inhibits lower levels
// - non-specific EOI clears top in-service bit
// - specific EOI clears named in-service bit
// - special mask spares masked in-service bits
// - auto EOI at end of last acknowledge
// - rotation makes serviced level lowest priority
// - A0 low, D4 high restarts initialization
// - vanished request answers as level 7
`timescale 1ns/1ns
`default_nettype none
module pic_ctrl
(
	// clock and reset
	input wire logic I_CLK_SYS,
	input wire logic I_SYS_RST,
	// host write port
	input wire logic I_WR_N,
	input wire logic I_CS_N,
	input wire logic I_PORT_SEL,
	input wire logic [7:0] I_DATA,
	output logic [7:0] O_DATA,
	output logic O_DATA_OE,
	// interrupt handshake
	input wire logic I_ACK_N,
	output logic O_INT,
	// request inputs
	input wire logic [7:0] I_REQ,
	// cascade lines
	input wire logic [2:0] I_CAS,
	output logic [2:0] O_CAS,
	output logic O_CAS_OE,
	// slave program / buffer enable
	input wire logic I_SP_N,
	output logic O_BUF_EN_N,
	output logic O_BUF_EN_OE
);
	import pic_pkg::*;
	// synchroniser stages, first stage read only by the second
	logic [SYNC_W-1:0] sync1_reg;
	logic [SYNC_W-1:0] sync2_reg;
	// edge history
	logic wr_act_d_reg;
	logic ack_low_d_reg;
	logic [7:0] req_d_reg;
	logic [7:0] data_hold_reg; // byte captured while the write is active
	// programmed state
	pic_init_t state_reg;
	pic_init_t state_next;
	logic [7:0] word_one_reg;
	logic [7:0] vector_base_reg;
	logic [7:0] cascade_map_reg;
	logic [4:0] options_reg;
	logic [7:0] mask_reg;
	logic smm_reg;
	logic auto_rot_reg;
	logic [2:0] low_reg;
	// interrupt state
	logic [7:0] armed_reg; // edge latches
	logic [7:0] isr_reg;
	logic seq_reg; // acknowledge sequence running
	logic [1:0] idx_reg; // acknowledge pulse index
	logic [2:0] ack_lvl_reg;
	logic ack_slave_reg; // frozen level has a slave behind it
	logic ack_dflt_reg; // default level 7 answer
	// synchronised pins
	wire [7:0] req_s = sync2_reg[23:16];
	wire [7:0] data_s = sync2_reg[15:8];
	wire [2:0] cas_s = sync2_reg[7:5];
	wire wr_n_s = sync2_reg[4];
	wire cs_n_s = sync2_reg[3];
	wire a0_s = sync2_reg[2];
	wire ack_n_s = sync2_reg[1];
	wire sp_n_s = sync2_reg[0];
	// strobes
	wire wr_act = ~wr_n_s & ~cs_n_s;
	wire write_take = wr_act_d_reg & ~wr_act; // write acts at its trailing edge
	wire ack_low = ~ack_n_s;
	wire ack_fall = ack_low & ~ack_low_d_reg;
	wire ack_rise = ~ack_low & ack_low_d_reg;
	// write decode
	wire wr_init_word_one = write_take & ~a0_s & data_hold_reg[F1_SEL];
	wire wr_word = write_take & ~wr_init_word_one;
	wire ready = (state_reg == ST_READY);
	wire wr_mask = ready & wr_word & a0_s;
	wire wr_op_word_eoi_rotate = ready & wr_word & ~a0_s & ~data_hold_reg[FO_OP_WORD_MASK_MODE_READ];
	wire wr_op_word_mask_mode_read = ready & wr_word & ~a0_s & data_hold_reg[FO_OP_WORD_MASK_MODE_READ];
	wire [2:0] op_code = data_hold_reg[FO_R:FO_EOI];
	wire [2:0] op_lvl = data_hold_reg[2:0];
	// mode fields
	wire level_trigger_bit = word_one_reg[F1_LEVEL_TRIGGER_BIT];
	wire interval_bit = word_one_reg[F1_ADI];
	wire single_controller_bit = word_one_reg[F1_SINGLE_CONTROLLER_BIT];
	wire ic4 = word_one_reg[F1_IC4];
	wire special_nesting_bit = options_reg[F4_SPECIAL_NESTING_BIT];
	wire buf_mode = options_reg[F4_BUF];
	wire auto_eoi_bit = options_reg[F4_AUTO_EOI_BIT];
	wire upm = options_reg[F4_UPM];
	// role: pin in plain mode, role bit in buffered mode
	wire master = single_controller_bit | (buf_mode ? options_reg[F4_MS] : sp_n_s);
	wire cas_master = master & ~single_controller_bit;
	wire cas_match = (cas_s == cascade_map_reg[2:0]);
	// request register: level mode follows the pin, edge mode needs an armed latch
	wire [7:0] request_register = level_trigger_bit ? req_s : (armed_reg & req_s);
	wire [7:0] req_rise = req_s & ~req_d_reg;
	// special nesting lets a slave input interrupt over its own in-service bit
	wire [7:0] same_ok = (special_nesting_bit & cas_master) ? cascade_map_reg : 8'h00;
	logic int_valid;
	logic [2:0] int_level;
	logic top_valid;
	logic [2:0] top_level;
	pic_prio u_prio
	(
		.i_req(request_register & ~mask_reg),
		.i_isr(isr_reg),
		.i_mask(mask_reg),
		.i_low(low_reg),
		.i_smm(smm_reg),
		.i_same_ok(same_ok),
		.o_int_valid(int_valid),
		.o_int_level(int_level),
		.o_top_valid(top_valid),
		.o_top_level(top_level)
	);
	// acknowledge bookkeeping
	wire first_ack = ack_fall & ~seq_reg;
	wire [2:0] frz_lvl = int_valid ? int_level : DEFAULT_LVL;
	wire [1:0] last_idx = upm ? LAST_IDX_VEC : LAST_IDX_CALL;
	wire seq_end = ack_rise & seq_reg & (idx_reg == last_idx);
	wire auto_eoi_bit_now = seq_end & auto_eoi_bit & top_valid;
	// end-of-interrupt decode
	wire ns_eoi = wr_op_word_eoi_rotate & ((op_code == OP_NS_EOI) | (op_code == OP_ROT_EOI)) & top_valid;
	wire sp_eoi = wr_op_word_eoi_rotate & (op_code == OP_SP_EOI);
	wire rot_now = (wr_op_word_eoi_rotate & (op_code == OP_ROT_EOI) & top_valid) | (auto_eoi_bit_now & auto_rot_reg);
	wire [7:0] top_bit = 8'h01 << top_level;
	wire [7:0] isr_clr = ((ns_eoi | auto_eoi_bit_now) ? top_bit : 8'h00)
		| (sp_eoi ? (8'h01 << op_lvl) : 8'h00);
	wire [7:0] isr_set = (first_ack & int_valid) ? (8'h01 << int_level) : 8'h00;
	wire [7:0] isr_next = (isr_reg & ~isr_clr) | isr_set; // set wins over clear
	// answer bytes
	wire [2:0] lvl = ack_lvl_reg;
	wire [7:0] addr_lo = interval_bit ? {word_one_reg[F1_HI:5], lvl, 2'b00}
		: {word_one_reg[F1_HI:6], lvl, 3'b000};
	wire [7:0] vec_byte = {vector_base_reg[7:3], lvl};
	// later bytes: single, master with no slave there, or the addressed slave
	wire drive_late = single_controller_bit | (master & ~ack_slave_reg) | (~master & cas_match);
	wire [1:0] cur_idx = seq_reg ? idx_reg : 2'h0;
	wire [7:0] byte_call = (cur_idx == 2'h0) ? CALL_CODE
		: ((cur_idx == 2'h1) ? addr_lo : vector_base_reg);
	wire [7:0] out_byte = upm ? vec_byte : byte_call;
	wire drive_call = (cur_idx == 2'h0) ? master : drive_late;
	wire drive_now = ack_fall & (upm ? ((cur_idx == 2'h1) & drive_late) : drive_call);
	wire data_oe_next = ack_rise ? 1'b0 : (drive_now ? 1'b1 : O_DATA_OE);
	// pin synchroniser
	always_ff @(posedge I_CLK_SYS)
	begin
		sync1_reg <= {I_REQ, I_DATA, I_CAS, I_WR_N, I_CS_N, I_PORT_SEL, I_ACK_N, I_SP_N};
		sync2_reg <= sync1_reg;
	end
	// edge history and write capture
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SYS_RST)
		begin
			wr_act_d_reg <= 1'b0;
			ack_low_d_reg <= 1'b0;
			req_d_reg <= 8'h00;
			data_hold_reg <= 8'h00;
		end
		else
		begin
			wr_act_d_reg <= wr_act;
			ack_low_d_reg <= ack_low;
			req_d_reg <= req_s;
			if (wr_act)
				data_hold_reg <= data_s;
		end
	end
	// init word order
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			ST_IDLE, ST_READY:
				state_next = state_reg;
			ST_W2:
				if (wr_word)
					state_next = !single_controller_bit ? ST_W3 : (ic4 ? ST_W4 : ST_READY);
			ST_W3:
				if (wr_word)
					state_next = ic4 ? ST_W4 : ST_READY;
			ST_W4:
				if (wr_word)
					state_next = ST_READY;
		endcase
		if (wr_init_word_one)
			state_next = ST_W2;
	end
	// programming registers
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SYS_RST)
		begin
			state_reg <= ST_IDLE;
			word_one_reg <= 8'h00;
			vector_base_reg <= 8'h00;
			cascade_map_reg <= CASMAP_RST;
			options_reg <= 5'h00;
			mask_reg <= MASK_RST;
			smm_reg <= 1'b0;
			auto_rot_reg <= 1'b0;
			low_reg <= LOW_RST;
		end
		else
		begin
			state_reg <= state_next;
			if (wr_init_word_one)
			begin
				// fresh sequence: mask open, nested priority, options cleared
				word_one_reg <= data_hold_reg;
				mask_reg <= MASK_RST;
				smm_reg <= 1'b0;
				low_reg <= LOW_RST;
				cascade_map_reg <= CASMAP_RST;
				options_reg <= 5'h00;
			end
			if (wr_word && state_reg == ST_W2)
				vector_base_reg <= data_hold_reg;
			if (wr_word && state_reg == ST_W3)
				cascade_map_reg <= data_hold_reg;
			if (wr_word && state_reg == ST_W4)
				options_reg <= data_hold_reg[4:0];
			if (wr_mask)
				mask_reg <= data_hold_reg;
			if (wr_op_word_mask_mode_read && data_hold_reg[FO_ENABLE_SPECIAL_MASK_BIT])
				smm_reg <= data_hold_reg[FO_SMM];
			if (wr_op_word_eoi_rotate && op_code == OP_ROT_SET)
				auto_rot_reg <= 1'b1;
			if (wr_op_word_eoi_rotate && op_code == OP_ROT_CLR)
				auto_rot_reg <= 1'b0;
			if (rot_now)
				low_reg <= top_level;
		end
	end
	// request latches and in-service bits
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SYS_RST || wr_init_word_one)
		begin
			armed_reg <= 8'h00;
			isr_reg <= 8'h00;
		end
		else
		begin
			// a new rising edge wins over the acknowledge clear
			armed_reg <= (armed_reg & ~isr_set) | req_rise;
			isr_reg <= isr_next;
		end
	end
	// acknowledge sequence
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SYS_RST || wr_init_word_one)
		begin
			seq_reg <= 1'b0;
			idx_reg <= 2'h0;
			ack_lvl_reg <= 3'h0;
			ack_slave_reg <= 1'b0;
			ack_dflt_reg <= 1'b0;
		end
		else
		begin
			if (first_ack)
			begin
				// freeze the winner at the first pulse
				seq_reg <= 1'b1;
				ack_lvl_reg <= frz_lvl;
				ack_slave_reg <= cascade_map_reg[frz_lvl];
				ack_dflt_reg <= ~int_valid;
			end
			if (seq_end)
			begin
				seq_reg <= 1'b0;
				idx_reg <= 2'h0;
			end
			else if (ack_rise && seq_reg)
				idx_reg <= idx_reg + 2'h1;
		end
	end
	// output pins, all registered
	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SYS_RST)
		begin
			O_INT <= 1'b0;
			O_DATA <= 8'h00;
			O_DATA_OE <= 1'b0;
			O_CAS <= 3'h0;
			O_CAS_OE <= 1'b0;
			O_BUF_EN_N <= 1'b1;
			O_BUF_EN_OE <= 1'b0;
		end
		else
		begin
			O_INT <= ready & int_valid & ~seq_reg;
			if (drive_now)
				O_DATA <= out_byte;
			O_DATA_OE <= data_oe_next;
			// master names the slave on the cascade lines from the first pulse
			O_CAS_OE <= ready & cas_master;
			if (first_ack && cascade_map_reg[frz_lvl])
				O_CAS <= frz_lvl;
			else if (seq_end)
				O_CAS <= 3'h0;
			// buffered mode turns the role pin into a low-active buffer enable
			O_BUF_EN_OE <= buf_mode;
			O_BUF_EN_N <= ~(buf_mode & data_oe_next);
		end
	end
	// checks
	default clocking cb @(posedge I_CLK_SYS); endclocking
	default disable iff (I_SYS_RST);
	a_call_byte: assert property (
		first_ack && ready && !upm && master |=> O_DATA == CALL_CODE && O_DATA_OE)
		else $error("call opcode not driven on first acknowledge");
	a_vector_byte: assert property (
		ack_fall && seq_reg && upm && idx_reg == 2'h1 && drive_late
		|=> O_DATA == {vector_base_reg[7:3], ack_lvl_reg} && O_DATA_OE)
		else $error("vector byte wrong");
	a_mask_load: assert property (
		wr_mask && !wr_init_word_one |=> mask_reg == $past(data_hold_reg))
		else $error("mask not loaded");
	a_init_restart: assert property (
		wr_init_word_one |=> state_reg == ST_W2 && mask_reg == MASK_RST && isr_reg == 8'h00)
		else $error("first init word did not restart");
	a_single_skip: assert property (
		state_reg == ST_W2 && wr_word && single_controller_bit && !ic4 |=> state_reg == ST_READY)
		else $error("third word not skipped");
	a_ns_eoi: assert property (
		ns_eoi && isr_set == 8'h00 |=> !isr_reg[$past(top_level)])
		else $error("non-specific eoi left bit set");
	a_default_lvl: assert property (
		first_ack && !int_valid && !wr_op_word_eoi_rotate |=> ack_lvl_reg == DEFAULT_LVL && ack_dflt_reg
		&& isr_reg == $past(isr_reg))
		else $error("default level answer wrong");
	a_nest_block: assert property (
		int_valid && !smm_reg && !special_nesting_bit |-> (isr_reg & (8'h01 << int_level)) == 8'h00)
		else $error("request at in-service level not blocked");
	a_auto_eoi: assert property (
		auto_eoi_bit_now && isr_set == 8'h00 |=> !isr_reg[$past(top_level)])
		else $error("auto eoi missed");
	c_init_done: cover property (state_reg == ST_W4 ##1 state_reg == ST_READY);
	c_ack_done: cover property (seq_end && !ack_dflt_reg);
	c_rotate: cover property (rot_now);
	c_smm_on: cover property (wr_op_word_mask_mode_read ##1 smm_reg);
endmodule : pic_ctrl
`default_nettype wire

// [pic_host_model.sv]
// Purpose: host model that writes command words and runs acknowledge pulses
// Assumes: pins change just after the falling clock edge, strobes held long
// Notes: a released data bus shows the inverted last word, never a stale copy
`timescale 1ns/1ns
`default_nettype none
module pic_host_model
(
	// clock
	input wire logic i_clk,
	// answer from the controller
	input wire logic [7:0] i_data,
	input wire logic i_data_oe,
	// host pins
	output logic o_wr_n,
	output logic o_cs_n,
	output logic o_a0,
	output logic [7:0] o_data,
	output logic o_ack_n
);
	// idle pins from time zero
	initial
	begin
		o_wr_n = 1'b1;
		o_cs_n = 1'b1;
		o_a0 = 1'b0;
		o_data = 8'h00;
		o_ack_n = 1'b1;
	end

	// one write: strobe low 4 clocks, idle 8 so the word lands first
	task automatic wr(input logic a0, input logic [7:0] d);
		@(negedge i_clk);
		o_a0 = a0;
		o_data = d;
		o_cs_n = 1'b0;
		o_wr_n = 1'b0;
		repeat (4) @(negedge i_clk);
		o_wr_n = 1'b1;
		o_cs_n = 1'b1;
		// released bus must not keep looking like the word just sent
		o_data = ~d;
		// strobe stays high long enough for the synchronised trailing edge
		repeat (8) @(negedge i_clk);
	endtask : wr

	// one acknowledge pulse; answer taken while the pulse is still low
	task automatic ack(output logic [7:0] d, output logic oe);
		@(negedge i_clk);
		o_ack_n = 1'b0;
		repeat (6) @(negedge i_clk);
		d = i_data;
		oe = i_data_oe;
		o_ack_n = 1'b1;
		repeat (7) @(negedge i_clk);
	endtask : ack
endmodule : pic_host_model
`default_nettype wire

// [prio_interrupt_ctrl_programming_tb.sv]
// Purpose: self-checking bench of the controller against an integer model
// Assumes: host model drives the write and acknowledge pins
// Notes: the last scenarios drive the role pin and cascade lines as master and slave
`timescale 1ns/1ns
`default_nettype none
module prio_interrupt_ctrl_programming_tb;
	import pic_pkg::*;
	// pins
	logic clk, rst, sp_n, wr_n, cs_n, a0, ack_n, o_int, o_data_oe, o_cas_oe;
	logic o_buf_en_n, o_buf_en_oe, aoe;
	logic [7:0] req, hdata, o_data;
	logic [2:0] cas_in, o_cas;
	// model state: in-service, edge latches, mask, lowest level
	logic [7:0] in_service_register, request_register, msk, w1, w2, r, m, ad;
	bit lvl_mode, vec_mode, auto_eoi_bit, special_mask_bit, rot_auto;
	int low, fails, checked, seed, k, l;

	pic_ctrl dut_u
	(
		.I_CLK_SYS(clk),
		.I_SYS_RST(rst),
		.I_WR_N(wr_n),
		.I_CS_N(cs_n),
		.I_PORT_SEL(a0),
		.I_DATA(hdata),
		.O_DATA(o_data),
		.O_DATA_OE(o_data_oe),
		.I_ACK_N(ack_n),
		.O_INT(o_int),
		.I_REQ(req),
		.I_CAS(cas_in),
		.O_CAS(o_cas),
		.O_CAS_OE(o_cas_oe),
		.I_SP_N(sp_n),
		.O_BUF_EN_N(o_buf_en_n),
		.O_BUF_EN_OE(o_buf_en_oe)
	);

	pic_host_model host_u
	(
		.i_clk(clk),
		.i_data(o_data),
		.i_data_oe(o_data_oe),
		.o_wr_n(wr_n),
		.o_cs_n(cs_n),
		.o_a0(a0),
		.o_data(hdata),
		.o_ack_n(ack_n)
	);

	// 100 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		if (fails == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	// winner by rotating scan; an in-service level blocks itself and below
	function automatic int pick();
		int n;
		logic [7:0] eff;
		eff = lvl_mode ? req : (request_register & req);
		for (int i = 0; i < 8; i++)
		begin
			n = (low + 1 + i) % 8;
			if (in_service_register[n] && !(special_mask_bit && msk[n]))
				return -1;
			if (eff[n] && !msk[n])
				return n;
		end
		return -1;
	endfunction : pick

	// clear the top in-service level, masked ones spared in special mask
	function automatic void ns_clear(input bit rot);
		int n;
		for (int i = 0; i < 8; i++)
		begin
			n = (low + 1 + i) % 8;
			if (in_service_register[n] && !(special_mask_bit && msk[n]))
			begin
				in_service_register[n] = 1'b0;
				if (rot)
					low = n;
				return;
			end
		end
	endfunction : ns_clear

	task automatic chk_int();
		chk({7'h0, o_int}, {7'h0, pick() >= 0});
	endtask : chk_int

	// edges latch only on a rise, so a held request stays serviced once
	task automatic setreq(input logic [7:0] v);
		@(negedge clk);
		request_register = request_register | (v & ~req);
		req = v;
		repeat (8) @(negedge clk);
		chk_int();
	endtask : setreq

	// a decoy first word is abandoned by the real one
	task automatic init(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		@(negedge clk);
		req = 8'h00;
		host_u.wr(1'b0, 8'h11);
		host_u.wr(1'b0, a);
		host_u.wr(1'b1, b);
		if (!a[1])
			host_u.wr(1'b1, 8'h05);
		if (a[0])
			host_u.wr(1'b1, c);
		repeat (8) @(negedge clk);
		w1 = a;
		w2 = b;
		lvl_mode = a[3];
		vec_mode = a[0] & c[0];
		auto_eoi_bit = a[0] & c[1];
		{in_service_register, request_register, msk, special_mask_bit, rot_auto} = '0;
		low = 7;
		chk({7'h0, o_buf_en_oe}, {7'h0, a[0] & c[3]});
	endtask : init

	task automatic intack();
		int n;
		logic [7:0] d;
		logic oe;
		n = pick();
		// a vanished request answers as level 7, nothing in service
		if (n < 0)
			n = 7;
		else
		begin
			// default answer leaves the edge latches as they are
			in_service_register[n] = 1'b1;
			request_register[n] = 1'b0;
		end
		if (vec_mode)
		begin
			host_u.ack(d, oe);
			chk({7'h0, oe}, 8'h00);
			host_u.ack(d, oe);
			chk(d, {w2[7:3], 3'(n)});
		end
		else
		begin
			host_u.ack(d, oe);
			chk(d, CALL_CODE);
			host_u.ack(d, oe);
			chk(d, w1[2] ? {w1[7:5], 3'(n), 2'b00} : {w1[7:6], 3'(n), 3'b000});
			host_u.ack(d, oe);
			chk(d, w2);
		end
		if (auto_eoi_bit)
			ns_clear(rot_auto);
		chk_int();
	endtask : intack

	task automatic eoi(input logic [7:0] cmd);
		host_u.wr(1'b0, cmd);
		repeat (8) @(negedge clk);
		if (cmd[6])
			in_service_register[cmd[2:0]] = 1'b0;
		else
			ns_clear(cmd[7]);
		chk_int();
	endtask : eoi

	// buffered mode: enable pin active whenever data is driven
	always @(negedge clk)
		if (o_data_oe === 1'b1 && o_buf_en_oe === 1'b1)
			chk({7'h0, o_buf_en_n}, 8'h00);

	// watchdog far beyond the few thousand cycles the run needs
	initial
	begin
		repeat (40000) @(posedge clk);
		fails++;
		summarize();
	end

	initial
	begin
		{rst, sp_n, cas_in, req} = {1'b1, 1'b1, 3'h0, 8'h00};
		seed = 32'hc2b0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		chk({3'h0, o_int, o_data_oe, o_cas_oe, o_buf_en_n, o_buf_en_oe}, 8'h02);
		// call mode, both intervals, nesting then non-specific clears
		for (k = 0; k < 4; k++)
		begin
			r = 8'($random(seed));
			init({r[7:5], 2'b10, k[0], 2'b10}, r ^ 8'h5a, 8'h00);
			l = $unsigned($random(seed)) % 8;
			setreq(8'h01 << l);
			intack();
			setreq(8'hff);
			intack();
			eoi(8'h20);
			eoi(8'h20);
		end
		// vector mode, level or edge, random mask, specific clear
		for (k = 0; k < 4; k++)
		begin
			m = 8'($random(seed));
			init({4'h1, k[0], k[1], 2'b11}, 8'($random(seed)), 8'h01);
			host_u.wr(1'b1, m);
			msk = m;
			setreq(8'hff);
			l = pick();
			intack();
			if (l >= 0)
				eoi(8'h60 | 8'(l));
		end
		init(8'h13, 8'h98, 8'h01);
		setreq(8'h08);
		@(negedge clk);
		req = 8'h00;
		repeat (4) @(negedge clk);
		intack();
		setreq(8'h0c);
		intack();
		eoi(8'ha0);
		setreq(8'h00);
		setreq(8'h0c);
		intack();
		// auto clear with auto rotation, buffered master
		init(8'h13, 8'h40, 8'h0f);
		host_u.wr(1'b0, 8'h80);
		rot_auto = 1'b1;
		setreq(8'h30);
		intack();
		intack();
		host_u.wr(1'b0, 8'h00);
		rot_auto = 1'b0;
		setreq(8'h00);
		setreq(8'h30);
		intack();
		// special mask: masked in-service level neither blocks nor clears
		init(8'h13, 8'h20, 8'h01);
		setreq(8'h08);
		intack();
		host_u.wr(1'b1, 8'h08);
		msk = 8'h08;
		host_u.wr(1'b0, 8'h28);
		setreq(8'h18);
		host_u.wr(1'b0, 8'h68);
		special_mask_bit = 1'b1;
		repeat (8) @(negedge clk);
		chk_int();
		intack();
		eoi(8'h20);
		host_u.wr(1'b0, 8'h48);
		special_mask_bit = 1'b0;
		setreq(8'h00);
		setreq(8'h10);
		// cascaded master: level 2 has a slave, so only the code goes out
		init(8'h11, 8'h48, 8'h01);
		setreq(8'h04);
		host_u.ack(ad, aoe);
		chk({7'h0, aoe}, 8'h00);
		chk({4'h0, o_cas_oe, o_cas}, 8'h0a);
		host_u.ack(ad, aoe);
		chk({7'h0, aoe}, 8'h00);
		in_service_register[2] = 1'b1;
		request_register[2] = 1'b0;
		chk_int();
		eoi(8'h20);
		// slave with identity 5 answers only while its code is on the lines
		sp_n = 1'b0;
		cas_in = 3'h5;
		init(8'h11, 8'h48, 8'h01);
		setreq(8'h02);
		intack();
		eoi(8'h20);
		cas_in = 3'h3;
		setreq(8'h00);
		setreq(8'h02);
		host_u.ack(ad, aoe);
		host_u.ack(ad, aoe);
		chk({7'h0, aoe}, 8'h00);
		summarize();
	end
endmodule : prio_interrupt_ctrl_programming_tb
`default_nettype wire
